// file: src/ciaf_consts.svh
`ifndef CIAF_CONSTS_SVH
`define CIAF_CONSTS_SVH
// =====================================================
// Register map
`define CIAF_ADDR_FLAGS 4'h0
`define CIAF_ADDR_STATUS 4'h1
`define CIAF_ADDR_SOFTINT 4'h2
// =====================================================
// Flag word layout
`define CIAF_BIT_ENABLE 0
`define CIAF_BIT_STACKSEL 1
`define CIAF_BIT_RSVD 2
`define CIAF_PPL_LSB 4
`define CIAF_PPL_MSB 6
// =====================================================
// Status word layout
`define CIAF_BIT_ACCEPT 0
`define CIAF_BIT_PENDING 1
// =====================================================
// Reset values and limits
`define CIAF_RST_ENABLE 1'b0
`define CIAF_RST_STACKSEL 1'b0
`define CIAF_RST_PPL 3'h0
`define CIAF_TRAP_MAX 6'h1f
`endif

// file: src/ciaf_pkg.sv
package ciaf_pkg;
    typedef logic [2:0] ciaf_level_type;
    typedef enum logic [0:0] {
        CIAF_STK_INTERRUPT = 1'b0,
        CIAF_STK_USER = 1'b1
    } ciaf_stack_type;
endpackage

// file: src/ciaf_level_compare.sv
`timescale 1ns/10ps
// Priority test of one request against the current level
module ciaf_level_compare (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire ciaf_pkg::ciaf_level_type reqLevel,
    input wire ciaf_pkg::ciaf_level_type curLevel,
    output logic aboveLevel
);
    // =====================================================
    // Registered compare, strictly greater
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aboveLevel <= 1'b0;
        end else begin
            aboveLevel <= (reqLevel > curLevel);
        end
    end
endmodule

// file: src/ciaf_flags.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "ciaf_consts.svh"
// What this block does
// - Maskable requests blocked while enable flag is 0, considered while 1.
// - Any interrupt acknowledge clears the enable flag in hardware.
// - Stack select 0 picks interrupt stack pointer, 1 picks user pointer.
// - Stack select clears on hardware acknowledge or trap vector 0 to 31.
// - Priority level field is three bits, levels 0 to 7.
// - Request enabled only if its priority strictly exceeds current level.
// - Software writes reserved bit as 0; reads return anything.
module ciaf_flags (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic irqRequest,
    input wire ciaf_pkg::ciaf_level_type irqLevel,
    input wire logic irqAck,
    input wire logic trapExec,
    input wire logic [5:0] trapVector,
    output logic irqAccept,
    output logic stackSelUser,
    output ciaf_pkg::ciaf_level_type levelOut
);
    logic enable_q;
    ciaf_pkg::ciaf_stack_type stackSel_q;
    ciaf_pkg::ciaf_level_type level_q;
    logic aboveLevel;
    logic reqHeld_q;
    logic hwClearSp;
    logic flagWr;

    // Only the flag word takes writes; other addresses are ignored
    assign flagWr = regWr && (regAddr == `CIAF_ADDR_FLAGS);

    // Trap with low vector numbers also returns to the interrupt stack
    assign hwClearSp = irqAck || (trapExec && (trapVector <= `CIAF_TRAP_MAX));

    // =====================================================
    // Enable flag; acknowledge beats a same-cycle software write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= `CIAF_RST_ENABLE;
        end else if (irqAck) begin
            enable_q <= 1'b0;
        end else if (flagWr) begin
            enable_q <= regWdata[`CIAF_BIT_ENABLE];
        end
    end

    // =====================================================
    // Stack select flag
    // Acknowledge and low traps share one term, so both beat a write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stackSel_q <= ciaf_pkg::CIAF_STK_INTERRUPT;
        end else if (hwClearSp) begin
            stackSel_q <= ciaf_pkg::CIAF_STK_INTERRUPT;
        end else if (flagWr) begin
            stackSel_q <= ciaf_pkg::ciaf_stack_type'(regWdata[`CIAF_BIT_STACKSEL]);
        end
    end

    // =====================================================
    // Processor priority level, three bits
    // Hardware never moves the level; only a flag write does
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= `CIAF_RST_PPL;
        end else if (flagWr) begin
            level_q <= regWdata[`CIAF_PPL_MSB:`CIAF_PPL_LSB];
        end
    end

    // =====================================================
    // Priority compare in its own stage
    ciaf_level_compare u_cmp (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .reqLevel(irqLevel),
        .curLevel(level_q),
        .aboveLevel(aboveLevel)
    );

    // Request delayed to line up with the registered compare
    // A request dropped for one cycle is seen as dropped; nothing latches it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reqHeld_q <= 1'b0;
        end else begin
            reqHeld_q <= irqRequest;
        end
    end

    // =====================================================
    // Acceptance; dropped at once on ack to avoid a double take
    // Request and level sampled at N, compare at N+1, accept shown at N+2;
    // the extra stage keeps the compare off the core's decode path
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqAccept <= 1'b0;
        end else begin
            irqAccept <= reqHeld_q && aboveLevel && enable_q && !irqAck;
        end
    end

    // =====================================================
    // Registered copies of stack select and level for the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stackSelUser <= 1'b0;
            levelOut <= `CIAF_RST_PPL;
        end else begin
            stackSelUser <= (stackSel_q == ciaf_pkg::CIAF_STK_USER);
            levelOut <= level_q;
        end
    end

    // =====================================================
    // Read port; reserved bit always reads 0, which is allowed
    // Status bits are raw snapshots; reading them clears nothing
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            regRdata <= 8'h00;
            case (regAddr)
                `CIAF_ADDR_FLAGS: begin
                    regRdata[`CIAF_BIT_ENABLE] <= enable_q;
                    regRdata[`CIAF_BIT_STACKSEL] <= stackSel_q;
                    regRdata[`CIAF_BIT_RSVD] <= 1'b0;
                    regRdata[`CIAF_PPL_MSB:`CIAF_PPL_LSB] <= level_q;
                end
                `CIAF_ADDR_STATUS: begin
                    regRdata[`CIAF_BIT_ACCEPT] <= irqAccept;
                    regRdata[`CIAF_BIT_PENDING] <= reqHeld_q;
                end
                default: begin
                    regRdata <= 8'h00;
                end
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // =====================================================
    // Checks; all share the core clock and reset
    // Enable flag: acknowledge clears it, only a write sets it
    a_ack_clears_en: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irqAck |=> !enable_q) else $error("enable survived ack");
    a_en_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (flagWr && !irqAck) |=> enable_q == $past(regWdata[`CIAF_BIT_ENABLE]))
        else $error("enable write lost");
    a_en_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!flagWr && !irqAck) |=> $stable(enable_q)) else $error("enable changed unasked");

    // Stack select: both hardware clears beat a same-cycle write
    a_trap_clears_sp: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (trapExec && trapVector <= `CIAF_TRAP_MAX) |=> stackSel_q == ciaf_pkg::CIAF_STK_INTERRUPT)
        else $error("stack select survived trap");
    a_ack_clears_sp: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irqAck |=> stackSel_q == ciaf_pkg::CIAF_STK_INTERRUPT) else $error("stack select survived ack");
    a_high_trap_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (trapExec && trapVector > `CIAF_TRAP_MAX && !irqAck && !flagWr) |=> $stable(stackSel_q))
        else $error("high trap vector moved stack select");
    a_sp_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (flagWr && !hwClearSp) |=> stackSel_q == $past(regWdata[`CIAF_BIT_STACKSEL]))
        else $error("stack select write lost");
    a_stack_out: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stackSelUser == $past(stackSel_q == ciaf_pkg::CIAF_STK_USER))
        else $error("stack output wrong");

    // Priority level: only software moves it; the copy trails by one cycle
    a_level_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        flagWr |=> level_q == $past(regWdata[`CIAF_PPL_MSB:`CIAF_PPL_LSB]))
        else $error("level write lost");
    a_level_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !flagWr |=> $stable(level_q)) else $error("level changed unasked");
    a_level_out: assert property (@(posedge clk_sys) disable iff (!arst_n)
        levelOut == $past(level_q)) else $error("level output wrong");

    // Acceptance: each term is checked at the stage where it was sampled
    a_cmp_strict: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $past(arst_n) |-> aboveLevel == ($past(irqLevel) > $past(level_q)))
        else $error("priority compare wrong");
    a_pending_track: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $past(arst_n) |-> reqHeld_q == $past(irqRequest))
        else $error("delayed request wrong");
    a_accept_needs_en: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irqAccept |-> $past(enable_q)) else $error("accept while disabled");
    a_accept_needs_lvl: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irqAccept |-> $past(irqRequest, 2) && ($past(irqLevel, 2) > $past(level_q, 2)))
        else $error("accept without priority");
    a_accept_full: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (reqHeld_q && aboveLevel && enable_q && !irqAck) |=> irqAccept)
        else $error("accept missed");
    a_no_acc_disabled: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !enable_q |=> !irqAccept) else $error("accept after disable");
    a_no_acc_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !aboveLevel |=> !irqAccept) else $error("accept at low priority");
    a_ack_drops_acc: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irqAck |=> !irqAccept) else $error("accept held through ack");

    // Read port: reserved bit always reads 0, which software must tolerate
    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        regRdata[`CIAF_BIT_RSVD] == 1'b0) else $error("reserved bit nonzero");
    a_en_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regRd && regAddr == `CIAF_ADDR_FLAGS) |=> regRdata[`CIAF_BIT_ENABLE] == $past(enable_q))
        else $error("enable readback wrong");
    a_sp_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regRd && regAddr == `CIAF_ADDR_FLAGS) |=> regRdata[`CIAF_BIT_STACKSEL] == $past(stackSel_q))
        else $error("stack select readback wrong");
    a_level_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regRd && regAddr == `CIAF_ADDR_FLAGS) |=> regRdata[`CIAF_PPL_MSB:`CIAF_PPL_LSB] == $past(level_q))
        else $error("level readback wrong");
    a_status_accept: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regRd && regAddr == `CIAF_ADDR_STATUS) |=> regRdata[`CIAF_BIT_ACCEPT] == $past(irqAccept))
        else $error("accept readback wrong");
    a_status_pending: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regRd && regAddr == `CIAF_ADDR_STATUS) |=> regRdata[`CIAF_BIT_PENDING] == $past(reqHeld_q))
        else $error("pending readback wrong");
endmodule

// file: verification/ciaf_irq_source.sv
`timescale 1ns/10ps
// ====
// Request source and acknowledge sequencer
module ciaf_irq_source (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reqOn,
    input wire ciaf_pkg::ciaf_level_type reqLevel,
    input wire logic ackOn,
    input wire logic [1:0] ackWait,
    input wire logic irqAccept,
    output logic irqRequest,
    output ciaf_pkg::ciaf_level_type irqLevel,
    output logic irqAck
);
    logic [1:0] waitCnt_q;
    // Idle level lines flip so a stale value never looks valid
    assign irqRequest = reqOn;
    assign irqLevel = reqOn ? reqLevel : ~reqLevel;
    // One ack pulse after ackWait cycles of accept; slow wait exposes races
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            waitCnt_q <= 2'h0;
            irqAck <= 1'b0;
        end else begin
            irqAck <= ackOn && irqAccept && !irqAck && waitCnt_q == ackWait;
            waitCnt_q <= (irqAccept && waitCnt_q != ackWait) ? waitCnt_q + 2'h1 : 2'h0;
        end
    end
endmodule

// file: verification/ciaf_flags_tb.sv
`timescale 1ns/10ps
`include "ciaf_consts.svh"
module ciaf_flags_tb;
    logic clk_sys, arst_n, regWr, regRd, reqOn, ackOn, trapExec;
    logic irqRequest, irqAck, irqAccept, stackSelUser;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [5:0] trapVector;
    logic [1:0] ackWait;
    ciaf_pkg::ciaf_level_type reqLevel, irqLevel, levelOut;
    int miscompares, checks_done, i;
    // ====
    // Clock and instances
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    ciaf_flags dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqRequest(irqRequest), .irqLevel(irqLevel),
        .irqAck(irqAck), .trapExec(trapExec), .trapVector(trapVector), .irqAccept(irqAccept),
        .stackSelUser(stackSelUser), .levelOut(levelOut));
    ciaf_irq_source src_u (.clk_sys(clk_sys), .arst_n(arst_n), .reqOn(reqOn), .reqLevel(reqLevel),
        .ackOn(ackOn), .ackWait(ackWait), .irqAccept(irqAccept), .irqRequest(irqRequest),
        .irqLevel(irqLevel), .irqAck(irqAck));
    // ====
    // Access and compare tasks
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // Read data stands one cycle only, so it is taken just after the edge
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    // Reserved bit always written as 0
    function automatic logic [7:0] flg(logic e, logic u, logic [2:0] p);
        return (8'(p) << `CIAF_PPL_LSB) | (8'(u) << `CIAF_BIT_STACKSEL) | 8'(e);
    endfunction
    // ====
    // Main sequence
    initial begin
        {arst_n, regWr, regRd, reqOn, ackOn, trapExec} = 6'h00;
        {regAddr, regWdata, trapVector, ackWait, reqLevel} = 23'h0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`CIAF_ADDR_FLAGS, 8'h00);
        rd(`CIAF_ADDR_STATUS, 8'h00);
        rd(4'hf, 8'h00);
        wr(`CIAF_ADDR_FLAGS, flg(1'b1, 1'b1, 3'h7));
        rd(`CIAF_ADDR_FLAGS, flg(1'b1, 1'b1, 3'h7));
        #1 chk({7'h0, stackSelUser}, 8'h01);
        @(posedge clk_sys);
        reqOn <= 1'b1;
        reqLevel <= 3'h4;
        // Sweep every level against a fixed request priority
        for (i = 0; i < 8; i++) begin
            wr(`CIAF_ADDR_FLAGS, flg(1'b1, 1'b0, 3'(i)));
            repeat (3) @(posedge clk_sys);
            #1 chk({7'h0, irqAccept}, {7'h0, i < 4});
            chk({5'h0, levelOut}, 8'(i));
            rd(`CIAF_ADDR_STATUS, {6'h0, 1'b1, i < 4});
        end
        wr(`CIAF_ADDR_FLAGS, flg(1'b0, 1'b1, 3'h0));
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h0, irqAccept}, 8'h00);
        @(posedge clk_sys);
        ackWait <= 2'h2;
        ackOn <= 1'b1;
        reqLevel <= 3'h5;
        wr(`CIAF_ADDR_FLAGS, flg(1'b1, 1'b1, 3'h2));
        // Bounded wait for the slow acknowledge
        for (i = 0; i < 20 && irqAck !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 20) begin
            miscompares++;
            test_done;
        end
        // Request stays up, so only the cleared enable can hold accept low
        @(posedge clk_sys);
        ackOn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, irqAccept}, 8'h00);
        chk({7'h0, stackSelUser}, 8'h00);
        rd(`CIAF_ADDR_FLAGS, flg(1'b0, 1'b0, 3'h2));
        // Trap vectors on both sides of the boundary
        for (i = 31; i < 33; i++) begin
            wr(`CIAF_ADDR_FLAGS, flg(1'b0, 1'b1, 3'h2));
            @(posedge clk_sys);
            trapExec <= 1'b1;
            trapVector <= 6'(i);
            @(posedge clk_sys);
            trapExec <= 1'b0;
            rd(`CIAF_ADDR_FLAGS, flg(1'b0, i > 31, 3'h2));
        end
        test_done;
    end
endmodule
